// ==== core/arcb_core.sv ====
// Command interpreter running one program packet against memory
// Contract
// - A program packet holds at most 44 bytes.
// - Ten modes: five operations, each plain or incrementing.
// - Only reads fill the return buffer; no reads, no return packet.
// - Write stores value; AND, OR, XOR merge with location and store.
// - Plain mode fetches a fresh address and parameters every execution.
// - Incrementing mode fetches only parameters; address advances by one.
// - After its count, incrementing mode falls back to plain same operation.
// - In plain mode address bytes 0..10 are commands, 11 up addresses.
// - Code 0 exits; 1..10 select read, write, AND, OR, XOR pairs.
// - Packet end terminates exactly like an exit code.
// - Count byte 1 upward, 0 means 256; first address follows.
// - First address byte after a mode switch is always an address.
// - Switching to the already active mode is a normal switch.
// - Plain read: each address byte reads one location into buffer.
// - Incrementing read reads count consecutive locations from start.
// - Read results leave as one packet after the program ends.
`timescale 1ns/1ps
`default_nettype none
module arcb_core import arcb_pkg::*; #(
   parameter int PKT_MAX = ARCB_PKT_MAX,
   parameter int AW = ARCB_ADDR_W
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic cmd_last_i,
   output logic cmd_ready_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [AW-1:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   output logic ret_valid_o,
   output logic [7:0] ret_data_o,
   output logic ret_last_o,
   input wire logic ret_ready_i,
   output logic busy_o,
   output logic overflow_o
);
   arcb_state_e state;
   arcb_state_e next_state;
   arcb_op_e op;
   arcb_op_e next_op;
   logic incr;
   logic [8:0] reps;
   logic first_addr;
   logic [AW-1:0] addr;
   logic [7:0] val;
   logic [5:0] nbytes;
   logic pkt_end;
   logic [7:0] alu_res;
   logic [5:0] ret_count;
   logic buf_busy;
   logic next_incr;
   logic [8:0] next_reps;

   // Decoding shared by the address and mode stages
   function automatic logic is_cmd(input logic [7:0] b);
      return b <= ARCB_CODE_MAX;
   endfunction
   function automatic arcb_op_e code_op(input logic [7:0] b);
      logic [7:0] k;
      k = (b - 8'h01) >> 1;
      return arcb_op_e'(k[2:0]);
   endfunction

   wire take = cmd_valid_i && cmd_ready_o;
   wire fetch_state = state inside {ARCB_S_MODE, ARCB_S_COUNT, ARCB_S_ADDR, ARCB_S_VAL};
   assign cmd_ready_o = fetch_state;
   // The byte that reaches the packet limit closes the program early
   wire at_limit = (nbytes == 6'(PKT_MAX - 1));
   wire end_now = take && (cmd_last_i || at_limit);
   wire byte_cmd = is_cmd(cmd_data_i) && !first_addr && !(incr && reps != 9'h000);
   wire needs_val = (op != ARCB_OP_READ);
   wire rep_done = incr && (reps == 9'h001);

   assign mem_req_o = (state == ARCB_S_RD) || (state == ARCB_S_WR);
   assign mem_we_o = (state == ARCB_S_WR);
   assign mem_addr_o = addr;
   assign mem_wdata_o = alu_res;
   assign busy_o = (state != ARCB_S_IDLE);

   arcb_alu u_alu (
      .op_i(op),
      .cur_i(mem_rdata_i),
      .val_i(val),
      .res_o(alu_res)
   );

   arcb_ret_buf #(.DEPTH(PKT_MAX), .AW(6)) u_buf (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      // Cleared as a new program starts; the last return packet has left by then
      .clr_i(state == ARCB_S_IDLE && cmd_valid_i),
      .push_i(state == ARCB_S_RD && op == ARCB_OP_READ),
      .push_data_i(mem_rdata_i),
      .send_i(state == ARCB_S_FLUSH),
      .ret_ready_i(ret_ready_i),
      .ret_valid_o(ret_valid_o),
      .ret_data_o(ret_data_o),
      .ret_last_o(ret_last_o),
      .count_o(ret_count),
      .busy_o(buf_busy)
   );
   assign overflow_o = (ret_count == 6'(PKT_MAX)) && !buf_busy;

   always_comb begin
      next_state = state;
      next_op = op;
      next_incr = incr;
      next_reps = reps;
      case (state)
         ARCB_S_IDLE: begin
            if (cmd_valid_i) begin
               next_state = ARCB_S_MODE;
            end
         end
         ARCB_S_MODE, ARCB_S_ADDR: begin
            if (take && (state == ARCB_S_MODE || byte_cmd)) begin
               if (cmd_data_i == ARCB_CODE_EXIT || cmd_data_i > ARCB_CODE_MAX) begin
                  next_state = ARCB_S_FLUSH;
               end else begin
                  // Re-selecting the active mode is just another switch
                  next_op = code_op(cmd_data_i);
                  next_incr = ~cmd_data_i[0];
                  next_state = cmd_data_i[0] ? ARCB_S_ADDR : ARCB_S_COUNT;
                  if (end_now) begin
                     next_state = ARCB_S_FLUSH;
                  end
               end
            end else if (take) begin
               // Address byte; read acts now, others wait for value
               next_state = needs_val ? ARCB_S_VAL : ARCB_S_RD;
               if (end_now && needs_val) begin
                  next_state = ARCB_S_FLUSH;
               end
            end
         end
         ARCB_S_COUNT: begin
            if (take) begin
               next_reps = (cmd_data_i == 8'h00) ? ARCB_REP_ZERO : {1'b0, cmd_data_i};
               next_state = end_now ? ARCB_S_FLUSH : ARCB_S_ADDR;
            end
         end
         ARCB_S_VAL: begin
            if (take) begin
               next_state = ARCB_S_RD;
            end
         end
         ARCB_S_RD: begin
            next_state = (op == ARCB_OP_READ) ? ARCB_S_ADDR : ARCB_S_WR;
            if (op == ARCB_OP_READ && incr && !rep_done) begin
               next_state = ARCB_S_RD;
            end
            if (op == ARCB_OP_READ) begin
               if (rep_done) begin
                  next_incr = 1'b0;
               end
               if (incr) begin
                  next_reps = reps - 9'h001;
               end
               if (pkt_end && !(incr && !rep_done)) begin
                  next_state = ARCB_S_FLUSH;
               end
            end
         end
         ARCB_S_WR: begin
            next_state = (incr && !rep_done) ? ARCB_S_VAL : ARCB_S_ADDR;
            if (rep_done) begin
               next_incr = 1'b0;
            end
            if (incr) begin
               next_reps = reps - 9'h001;
            end
            if (pkt_end) begin
               next_state = ARCB_S_FLUSH;
            end
         end
         ARCB_S_FLUSH: begin
            next_state = ARCB_S_SEND;
         end
         ARCB_S_SEND: begin
            if (!buf_busy) begin
               next_state = ARCB_S_IDLE;
            end
         end
         default: begin
            next_state = ARCB_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ARCB_S_IDLE;
         op <= ARCB_OP_READ;
         incr <= 1'b0;
         reps <= 9'h000;
      end else begin
         state <= next_state;
         op <= next_op;
         incr <= next_incr;
         reps <= next_reps;
      end
   end

   // Address, value and packet bookkeeping
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr <= '0;
         val <= 8'h00;
         nbytes <= ARCB_CNT_RST;
         pkt_end <= 1'b0;
         first_addr <= 1'b0;
      end else begin
         if (state == ARCB_S_IDLE) begin
            nbytes <= ARCB_CNT_RST;
            pkt_end <= 1'b0;
         end else if (take) begin
            nbytes <= nbytes + 6'h01;
            pkt_end <= pkt_end | cmd_last_i | at_limit;
         end
         if (take && state inside {ARCB_S_MODE, ARCB_S_ADDR} && next_state != ARCB_S_FLUSH
             && (state == ARCB_S_MODE || byte_cmd)) begin
            first_addr <= 1'b1;
         end else if (take && state == ARCB_S_ADDR) begin
            first_addr <= 1'b0;
            addr <= cmd_data_i[AW-1:0];
         end
         if (take && state == ARCB_S_VAL) begin
            val <= cmd_data_i;
         end
         if ((state == ARCB_S_WR || (state == ARCB_S_RD && op == ARCB_OP_READ)) && incr) begin
            addr <= addr + AW'(1);
         end
      end
   end

   // Checks on the interpreter's own state and outputs
   AST_CMD_BOUND: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take |-> nbytes < 6'(PKT_MAX)) else $error("packet over limit");
   AST_WR_AFTER_RD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mem_we_o |-> $past(state) == ARCB_S_RD && op != ARCB_OP_READ)
      else $error("write without fetch");
   AST_NO_RET_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mem_we_o |-> !u_buf.push_i) else $error("write pushed data");
   AST_ALU: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mem_we_o && op == ARCB_OP_XOR |-> mem_wdata_o == (mem_rdata_i ^ val))
      else $error("xor result wrong");
   AST_INC_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_WR && incr && !pkt_end |=> addr == $past(addr) + AW'(1))
      else $error("address not advanced");
   AST_FALLBACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_WR && rep_done |=> !incr) else $error("no fallback");
   AST_END_FLUSH: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_WR && pkt_end |=> state == ARCB_S_FLUSH)
      else $error("end not honoured");
   AST_RET_AFTER: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ret_valid_o |-> state == ARCB_S_SEND) else $error("early return");
   AST_COUNT_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_COUNT && take && cmd_data_i == 8'h00 |=> reps == 9'h100)
      else $error("zero count not 256");
   AST_FIRST_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take && state == ARCB_S_ADDR && first_addr |=> mem_addr_o == $past(cmd_data_i[AW-1:0]))
      else $error("first byte after switch not used as address");
   AST_PLAIN_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take && state == ARCB_S_ADDR && cmd_data_i > ARCB_CODE_MAX
      |=> mem_addr_o == $past(cmd_data_i[AW-1:0]) && state != ARCB_S_COUNT) else $error("no address");
   AST_SWITCH: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take && state == ARCB_S_ADDR && byte_cmd && cmd_data_i != ARCB_CODE_EXIT && !end_now
      |=> first_addr && incr == !$past(cmd_data_i[0]) && state inside {ARCB_S_ADDR, ARCB_S_COUNT})
      else $error("mode code not obeyed");
   AST_EXIT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take && state == ARCB_S_ADDR && byte_cmd && cmd_data_i == ARCB_CODE_EXIT
      |=> state == ARCB_S_FLUSH) else $error("exit code not obeyed");
   AST_INC_READ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_RD && op == ARCB_OP_READ && incr && !rep_done
      |=> state == ARCB_S_RD && mem_addr_o == $past(mem_addr_o) + AW'(1))
      else $error("read burst broken");
   AST_RD_FALLBACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_RD && op == ARCB_OP_READ && rep_done
      |=> !incr && state != ARCB_S_RD) else $error("read burst did not fall back");
   AST_NO_EMPTY_RET: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      state == ARCB_S_FLUSH && ret_count == 6'h00 |=> !ret_valid_o)
      else $error("empty return packet");
   AST_DROP_PART: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take && state == ARCB_S_ADDR && !byte_cmd && needs_val && end_now
      |=> state == ARCB_S_FLUSH && !mem_req_o) else $error("partial command executed");
   AST_RET_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ret_valid_o && !ret_ready_i |=> ret_valid_o && $stable(ret_data_o))
      else $error("return byte dropped");
   AST_LIMIT_END: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      take && at_limit |=> !cmd_ready_o)
      else $error("byte taken beyond packet limit");
   COV_READ_PKT: cover property (@(posedge mclk_i) ret_last_o && ret_ready_i);
   COV_INC_WRITE: cover property (@(posedge mclk_i) mem_we_o && incr);
   COV_LOW_ADDR: cover property (@(posedge mclk_i) mem_req_o && addr < 8'h0B);
   COV_SWITCH: cover property (@(posedge mclk_i) take && state == ARCB_S_ADDR && byte_cmd);
   COV_ZERO_COUNT: cover property (@(posedge mclk_i) state == ARCB_S_COUNT && take && cmd_data_i == 8'h00);
endmodule
`default_nettype wire

// ==== core/arcb_pkg.sv ====
// Package with constants and types of the command interpreter
package arcb_pkg;
   localparam int ARCB_PKT_MAX = 44;
   localparam int ARCB_DATA_W = 8;
   localparam int ARCB_ADDR_W = 8;
   localparam logic [7:0] ARCB_CODE_EXIT = 8'h00;
   localparam logic [7:0] ARCB_CODE_MAX = 8'h0A;
   localparam logic [8:0] ARCB_REP_ZERO = 9'h100;
   localparam logic [5:0] ARCB_CNT_RST = 6'h00;
   typedef enum logic [2:0] {ARCB_OP_READ, ARCB_OP_WRITE, ARCB_OP_AND, ARCB_OP_OR,
      ARCB_OP_XOR} arcb_op_e;
   typedef enum {ARCB_S_IDLE, ARCB_S_MODE, ARCB_S_COUNT, ARCB_S_ADDR, ARCB_S_VAL,
      ARCB_S_RD, ARCB_S_WR, ARCB_S_FLUSH, ARCB_S_SEND} arcb_state_e;
endpackage

// ==== core/arcb_ret_buf.sv ====
// Return packet buffer that collects read bytes and sends them out
`timescale 1ns/1ps
`default_nettype none
module arcb_ret_buf import arcb_pkg::*; #(
   parameter int DEPTH = ARCB_PKT_MAX,
   parameter int AW = 6
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic clr_i,
   input wire logic push_i,
   input wire logic [7:0] push_data_i,
   input wire logic send_i,
   input wire logic ret_ready_i,
   output logic ret_valid_o,
   output logic [7:0] ret_data_o,
   output logic ret_last_o,
   output logic [AW-1:0] count_o,
   output logic busy_o
);
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic sending;
   wire room = wptr < AW'(DEPTH);
   wire beat = sending && ret_ready_i;
   wire last_beat = (rptr + AW'(1)) == wptr;
   assign ret_valid_o = sending;
   assign ret_last_o = sending && last_beat;
   assign ret_data_o = mem[rptr];
   assign count_o = wptr;
   assign busy_o = sending;
   always_ff @(posedge mclk_i) begin
      if (push_i && room) begin
         mem[wptr] <= push_data_i;
      end
   end
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wptr <= ARCB_CNT_RST[AW-1:0];
         rptr <= ARCB_CNT_RST[AW-1:0];
         sending <= 1'b0;
      end else if (clr_i) begin
         wptr <= ARCB_CNT_RST[AW-1:0];
         rptr <= ARCB_CNT_RST[AW-1:0];
         sending <= 1'b0;
      end else begin
         if (push_i && room) begin
            wptr <= wptr + AW'(1);
         end
         // An empty buffer never starts a packet
         if (send_i && wptr != '0) begin
            sending <= 1'b1;
         end else if (beat && last_beat) begin
            sending <= 1'b0;
         end
         if (beat) begin
            rptr <= rptr + AW'(1);
         end
      end
   end
endmodule
`default_nettype wire

// ==== core/arcb_alu.sv ====
// Operation unit that forms the value written back to memory
`timescale 1ns/1ps
`default_nettype none
module arcb_alu import arcb_pkg::*; #(
   parameter int DW = ARCB_DATA_W
) (
   input wire arcb_op_e op_i,
   input wire logic [DW-1:0] cur_i,
   input wire logic [DW-1:0] val_i,
   output logic [DW-1:0] res_o
);
   wire [DW-1:0] and_v = cur_i & val_i;
   wire [DW-1:0] or_v = cur_i | val_i;
   wire [DW-1:0] xor_v = cur_i ^ val_i;
   // Write stores the value, logic ops merge with the location
   assign res_o = (op_i == ARCB_OP_AND) ? and_v :
                  (op_i == ARCB_OP_OR) ? or_v :
                  (op_i == ARCB_OP_XOR) ? xor_v : val_i;
endmodule
`default_nettype wire

// ==== sim/arcb_mem_model.sv ====
// Byte memory on the far side of the interpreter, read without a clock
`timescale 1ns/1ps
`default_nettype none
module arcb_mem_model (
   input wire logic mclk_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [0:255];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end
   // Outside an access the bus shows inverted data, so stale values are never trusted
   assign rdata_o = req_i ? mem[addr_i] : ~mem[addr_i];
   always @(posedge mclk_i) begin
      if (req_i && we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule
`default_nettype wire

// ==== sim/access_ram_command_backbone_test.sv ====
// Self-checking testbench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module access_ram_command_backbone_test import arcb_pkg::*;;
   logic mclk_i, rst_b_i, cmd_valid_i, cmd_last_i, cmd_ready_o, ret_ready_i, stall;
   logic mem_req_o, mem_we_o, ret_valid_o, ret_last_o, busy_o, overflow_o;
   logic [7:0] cmd_data_i, mem_addr_o, mem_wdata_o, mem_rdata_i, ret_data_o;
   logic [7:0] exp_mem [0:255];
   logic [7:0] got[$], exp_ret[$], prog[$];
   int mismatches, checked, cycles, last_n, rd_cnt;
   arcb_core arcb_core_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
      .cmd_data_i(cmd_data_i), .cmd_last_i(cmd_last_i), .cmd_ready_o(cmd_ready_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .ret_valid_o(ret_valid_o),
      .ret_data_o(ret_data_o), .ret_last_o(ret_last_o), .ret_ready_i(ret_ready_i),
      .busy_o(busy_o), .overflow_o(overflow_o));
   arcb_mem_model arcb_mem_model_i (.mclk_i(mclk_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      ret_ready_i <= #1 (!stall || !ret_ready_i);
      if (ret_valid_o === 1'b1 && ret_ready_i === 1'b1) begin
         got.push_back(ret_data_o);
         if (ret_last_o === 1'b1) last_n = got.size();
      end
      cycles++;
      if (mem_req_o === 1'b1 && mem_we_o !== 1'b1) rd_cnt++;
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, g, e);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic last);
      int n;
      n = 0;
      cmd_valid_i = 1'b1;
      cmd_data_i = b;
      cmd_last_i = last;
      while (cmd_ready_o !== 1'b1 && n < 50) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk(8'(n == 50), 8'h00, "byte not taken");
      @(posedge mclk_i);
      #1;
   endtask
   // Sends a program, waits for the end and judges returns and memory
   task automatic run(input string name, input bit mark_last);
      int n;
      got.delete();
      last_n = 0;
      foreach (prog[i]) send(prog[i], mark_last && i == prog.size() - 1);
      cmd_valid_i = 1'b0;
      cmd_last_i = 1'b0;
      n = 0;
      while (busy_o !== 1'b0 && n < 3000) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk(8'(n >= 3000), 8'h00, "program not finished");
      chk(8'(got.size()), 8'(exp_ret.size()), "return count");
      foreach (exp_ret[i]) chk(got[i], exp_ret[i], "return byte");
      if (exp_ret.size() > 0) chk(8'(last_n), 8'(exp_ret.size()), "last flag");
      for (int a = 0; a < 256; a++) chk(arcb_mem_model_i.mem[a], exp_mem[a], "memory");
      exp_ret.delete();
      $display("Test %s done", name);
   endtask
   task automatic t_plain_read();
      prog = '{8'h01, 8'h05, 8'h40, 8'h0B, 8'h00};
      exp_ret = '{exp_mem[8'h05], exp_mem[8'h40], exp_mem[8'h0B]};
      run("plain_read", 1'b1);
   endtask
   task automatic t_write_ops();
      // Host gives address then value for each plain operation
      prog = '{8'h03, 8'h30, 8'hA5, 8'h03, 8'h31, 8'h3C, 8'h05, 8'h30, 8'h0F, 8'h07, 8'h31,
         8'hC0, 8'h09, 8'h30, 8'hFF, 8'h00};
      exp_mem[8'h30] = (8'hA5 & 8'h0F) ^ 8'hFF;
      exp_mem[8'h31] = 8'h3C | 8'hC0;
      run("write_ops", 1'b0);
   endtask
   task automatic t_inc_modes();
      // Count follows the code, start address and values follow the count
      prog = '{8'h04, 8'h02, 8'h70, 8'h11, 8'h22, 8'h80, 8'h33, 8'h06, 8'h02, 8'h70, 8'h0F,
         8'hF0, 8'h08, 8'h02, 8'h72, 8'h01, 8'h02, 8'h0A, 8'h02, 8'h74, 8'hFF, 8'hFF,
         8'h02, 8'h03, 8'h70, 8'h71};
      exp_mem[8'h70] = 8'h11 & 8'h0F;
      exp_mem[8'h71] = 8'h22 & 8'hF0;
      exp_mem[8'h80] = 8'h33;
      exp_mem[8'h72] = exp_mem[8'h72] | 8'h01;
      exp_mem[8'h73] = exp_mem[8'h73] | 8'h02;
      exp_mem[8'h74] = ~exp_mem[8'h74];
      exp_mem[8'h75] = ~exp_mem[8'h75];
      exp_ret = '{exp_mem[8'h70], exp_mem[8'h71], exp_mem[8'h72], exp_mem[8'h71]};
      stall = 1'b1;
      run("inc_modes", 1'b1);
      stall = 1'b0;
   endtask
   task automatic t_truncated();
      prog = '{8'h03, 8'h40, 8'h55, 8'h41};
      exp_mem[8'h40] = 8'h55;
      run("truncated", 1'b1);
   endtask
   task automatic t_limit();
      // No end mark: the interpreter must stop after the 44th byte by itself
      prog = '{8'h01};
      for (int i = 0; i < ARCB_PKT_MAX - 1; i++) begin
         prog.push_back(8'h0B + 8'(i));
         exp_ret.push_back(exp_mem[8'h0B + 8'(i)]);
      end
      run("limit", 1'b0);
      chk(8'(overflow_o), 8'h00, "overflow flag");
   endtask
   task automatic t_count_zero();
      // Count byte zero reads 256 locations; only the first 44 fit the return packet
      prog = '{8'h02, 8'h00, 8'h20};
      for (int i = 0; i < ARCB_PKT_MAX; i++) exp_ret.push_back(exp_mem[8'h20 + 8'(i)]);
      rd_cnt = 0;
      run("count_zero", 1'b1);
      chk(8'(rd_cnt != 256), 8'h00, "reads of zero count");
      chk(8'(overflow_o), 8'h01, "overflow flag");
   endtask
   task automatic end_sim();
      $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i) ^ 8'h5A;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      rst_b_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_last_i = 1'b0;
      cmd_data_i = 8'h00;
      stall = 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
      rst_b_i = 1'b1;
      t_plain_read();
      t_write_ops();
      t_inc_modes();
      t_truncated();
      t_limit();
      t_count_zero();
      end_sim();
   end
endmodule
`default_nettype wire
